//--- tb_top.sv
// Self-checking bench for wdog_core with an integer timeout model.
// Assumes wdog_core.v and wdog_core_chk.sv are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       clock_i, sys_rst_i, wdt_enable_i, wdt_src_i, clr_mode_i;
    logic       irc_option_i, internal_osc_keep_enable_i, idle_mode_i;
    logic       irq_pending_i, external_reset_pin_n_i, b;
    logic [1:0] wdt_div_sel_i;
    logic [7:0] port_a_i, port_a_wake_en_i;
    logic [4:0] stb;
    wire        halt_exec_i, clear_watchdog_single_i, timer_flag_set_i;
    wire        clear_watchdog_first_i, clear_watchdog_second_i;
    wire        chip_reset_o, warm_reset_o, wake_o, halted_o;
    wire        timeout_flag_o, powerdown_flag_o, sys_osc_run_o;
    wire        internal_rc_oscillator_run_o, clock_out_pin_o;
    int         fail_count = 0, total_checks = 0, cyc = 0, c0, n, k, d;
    assign {halt_exec_i, clear_watchdog_single_i, clear_watchdog_first_i,
            clear_watchdog_second_i, timer_flag_set_i} = stb;
    wdog_core i_wdog_core (
        .clock_i                      (clock_i),
        .sys_rst_i                    (sys_rst_i),
        .wdt_enable_i                 (wdt_enable_i),
        .wdt_src_i                    (wdt_src_i),
        .wdt_div_sel_i                (wdt_div_sel_i),
        .clr_mode_i                   (clr_mode_i),
        .irc_option_i                 (irc_option_i),
        .internal_osc_keep_enable_i   (internal_osc_keep_enable_i),
        .idle_mode_i                  (idle_mode_i),
        .halt_exec_i                  (halt_exec_i),
        .clear_watchdog_single_i      (clear_watchdog_single_i),
        .clear_watchdog_first_i       (clear_watchdog_first_i),
        .clear_watchdog_second_i      (clear_watchdog_second_i),
        .external_reset_pin_n_i       (external_reset_pin_n_i),
        .port_a_i                     (port_a_i),
        .port_a_wake_en_i             (port_a_wake_en_i),
        .irq_pending_i                (irq_pending_i),
        .timer_flag_set_i             (timer_flag_set_i),
        .chip_reset_o                 (chip_reset_o),
        .warm_reset_o                 (warm_reset_o),
        .wake_o                       (wake_o),
        .halted_o                     (halted_o),
        .timeout_flag_o               (timeout_flag_o),
        .powerdown_flag_o             (powerdown_flag_o),
        .sys_osc_run_o                (sys_osc_run_o),
        .internal_rc_oscillator_run_o (internal_rc_oscillator_run_o),
        .clock_out_pin_o              (clock_out_pin_o)
    );
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) cyc <= cyc + 1;
    //**********************************************************
    // Tasks
    //**********************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic pulse(input logic [4:0] m);
        @(posedge clock_i) stb <= m;
        @(posedge clock_i) stb <= 5'h00;
        #1;
    endtask
    // Waits for a chip reset pulse, at most lim cycles; n is cycles waited.
    task automatic wait_rst(input int lim);
        n = 0;
        do begin
            @(posedge clock_i);
            #1;
            n++;
        end while (chip_reset_o !== 1'b1 && n < lim);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    //**********************************************************
    // Tests
    //**********************************************************
    initial begin
        {sys_rst_i, wdt_enable_i, wdt_src_i, external_reset_pin_n_i} = 4'hf;
        {clr_mode_i, irc_option_i, internal_osc_keep_enable_i} = 3'h0;
        {idle_mode_i, irq_pending_i, wdt_div_sel_i, stb} = 9'h000;
        port_a_i = 8'hff;
        port_a_wake_en_i = 8'h00;
        void'($urandom(78));
        repeat (16) @(posedge clock_i);
        check({chip_reset_o, wake_o, timeout_flag_o, sys_osc_run_o}, 4'h1);
        @(posedge clock_i) sys_rst_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1 b = clock_out_pin_o;
        repeat (2) @(posedge clock_i);
        #1 check(clock_out_pin_o, {~b});
        pulse(5'h08);
        c0 = cyc;
        wait_rst(20000);
        // The model: instruction clock is sysclk/4, times 2^(12+sel).
        check((cyc - c0 + 8) / 16, (4 << 12) / 16);
        check(timeout_flag_o, 1'b1);
        $display("normal timeout done");
        for (k = 0; k < 5; k++) begin
            d = 3500 + $urandom % 1000;
            wait_rst(d);
            check(n, d);
            pulse(5'h08);
        end
        $display("single clear done");
        @(posedge clock_i) {clr_mode_i, wdt_div_sel_i} <= 3'h5;
        pulse(5'h06);
        c0 = cyc;
        for (k = 0; k < 3; k++) begin
            wait_rst(8000);
            check(n, 8000);
            pulse(5'h04);
        end
        wait_rst(12000);
        check((cyc - c0 + 8) / 16, (4 << 13) / 16);
        $display("dual clear done");
        @(posedge clock_i) {wdt_enable_i, clr_mode_i, wdt_div_sel_i} <= 4'h0;
        pulse(5'h08);
        check(timeout_flag_o, 1'b1);
        wait_rst(17000);
        check(n, 17000);
        $display("disabled done");
        @(posedge clock_i) {wdt_enable_i, wdt_src_i} <= 2'h2;
        for (k = 0; k < 3; k++) begin
            pulse(5'h10);
            check({powerdown_flag_o, timeout_flag_o, halted_o}, 3'h5);
            @(posedge clock_i);
            #1 check({sys_osc_run_o, internal_rc_oscillator_run_o}, 2'h1);
            d = $urandom % 8;
            @(posedge clock_i);
            if (k == 0) irq_pending_i <= 1'b1;
            if (k == 1) port_a_wake_en_i <= 8'h01 << d;
            if (k == 1) port_a_i <= ~(8'h01 << d);
            if (k == 2) stb <= 5'h01;
            @(posedge clock_i) stb <= 5'h00;
            #1;
            for (n = 0; n < 8 && wake_o !== 1'b1; n++) #5;
            check(wake_o, 1'b1);
            @(posedge clock_i) irq_pending_i <= 1'b0;
            port_a_i <= 8'hff;
            repeat (3) @(posedge clock_i);
            #1 check(halted_o, 1'b0);
        end
        $display("halt wake done");
        @(posedge clock_i) {idle_mode_i, internal_osc_keep_enable_i} <= 2'h3;
        repeat (3) @(posedge clock_i);
        #1 check({sys_osc_run_o, internal_rc_oscillator_run_o}, 2'h1);
        @(posedge clock_i) {wdt_enable_i, internal_osc_keep_enable_i} <= 2'h0;
        repeat (3) @(posedge clock_i);
        #1 check(internal_rc_oscillator_run_o, 1'b0);
        @(posedge clock_i) {idle_mode_i, wdt_enable_i} <= 2'h1;
        external_reset_pin_n_i <= 1'b0;
        wait_rst(6);
        check(chip_reset_o, 1'b1);
        @(posedge clock_i) external_reset_pin_n_i <= 1'b1;
        $display("idle and pin done");
        complete_run();
    end
    // Run needs about 90000 cycles; this limit cuts a hang short.
    initial begin
        #480000;
        fail_count++;
        complete_run();
    end
endmodule // tb_top
bind wdog_core wdog_core_chk i_wdog_core_chk (
    .clock_i                      (clock_i),
    .sys_rst_i                    (sys_rst_i),
    .wdt_enable_i                 (wdt_enable_i),
    .clr_mode_i                   (clr_mode_i),
    .irc_option_i                 (irc_option_i),
    .internal_osc_keep_enable_i   (internal_osc_keep_enable_i),
    .idle_mode_i                  (idle_mode_i),
    .halt_exec_i                  (halt_exec_i),
    .clear_watchdog_single_i      (clear_watchdog_single_i),
    .external_reset_pin_n_i       (external_reset_pin_n_i),
    .irq_pending_i                (irq_pending_i),
    .chip_reset_o                 (chip_reset_o),
    .warm_reset_o                 (warm_reset_o),
    .wake_o                       (wake_o),
    .halted_o                     (halted_o),
    .timeout_flag_o               (timeout_flag_o),
    .powerdown_flag_o             (powerdown_flag_o),
    .sys_osc_run_o                (sys_osc_run_o),
    .internal_rc_oscillator_run_o (internal_rc_oscillator_run_o),
    .clock_out_pin_o              (clock_out_pin_o)
);
`default_nettype wire

//--- wdog_core.v
// Watchdog counter with clock source choice, divide ratio, clear policy,
// oscillator gating for idle and halt, reset and wake-up outputs.
// Assumes the core drives instruction strobes as one-cycle pulses on
// clock_i; the reset pin and port A pins are asynchronous.
//
// Notes on behaviour
// RULE1: Provide system clock and free internal RC.
// RULE2: Watchdog source: internal RC or sysclk/4.
// RULE3: Watchdog disabled makes its instructions no-ops.
// RULE4: Timeout divides RC period by 2^12..2^15.
// RULE5: Internal RC period about 65 microseconds.
// RULE6: Instruction-clock source stops counting in halt.
// RULE7: Noisy designs should pick internal RC source.
// RULE8: Normal overflow gives chip reset, sets timeout.
// RULE9: Idle/halt overflow warm-resets PC and SP only.
// RULE10: Reset pin low, clear, halt clear counter.
// RULE11: Single-clear mode: each clear clears immediately.
// RULE12: Dual-clear mode needs both clear instructions.
// RULE13: Idle stops system osc; RC kept if keep-enable.
// RULE14: Halt stops both unless keep or watchdog enabled.
// RULE15: Wake on interrupt, port A fall, overflow, timer.
// RULE16: Clock out pin gives system clock over four.
// RULE17: RC disabled when option and keep-enable both off; code keeps it running while the watchdog is enabled, except in idle mode.
// RULE18: Halt sets powerdown flag, clears timeout flag.
// RULE19: Clear restarts count; overflow at selected stage.
`timescale 1ns/1ps
`default_nettype none
`include "wdog_map.vh"
module wdog_core (
    input  wire       clock_i,               // 200 MHz system clock.
    input  wire       sys_rst_i,             // Async reset, active high.
    input  wire       wdt_enable_i,          // Config: watchdog enabled.
    input  wire       wdt_src_i,             // Config: 0 RC, 1 instr clk.
    input  wire [1:0] wdt_div_sel_i,         // Config: 2^(12+sel).
    input  wire       clr_mode_i,            // Config: 0 single, 1 dual.
    input  wire       irc_option_i,          // Config: RC option enabled.
    input  wire       internal_osc_keep_enable_i, // Keep-enable bit.
    input  wire       idle_mode_i,           // Core is in idle mode.
    input  wire       halt_exec_i,           // Halt instruction pulse.
    input  wire       clear_watchdog_single_i, // Single clear pulse.
    input  wire       clear_watchdog_first_i,  // First clear pulse.
    input  wire       clear_watchdog_second_i, // Second clear pulse.
    input  wire       external_reset_pin_n_i,  // Reset pin, active low.
    input  wire [7:0] port_a_i,              // Port A pins.
    input  wire [7:0] port_a_wake_en_i,      // Per-bit wake option.
    input  wire       irq_pending_i,         // Interrupt request.
    input  wire       timer_flag_set_i,      // Timer flag 0 to 1 pulse.
    output reg        chip_reset_o,          // Full chip reset pulse.
    output reg        warm_reset_o,          // PC and SP clear pulse.
    output reg        wake_o,                // Wake-up pulse.
    output reg        halted_o,              // Halt state held.
    output reg        timeout_flag_o,        // Timeout status flag.
    output reg        powerdown_flag_o,      // Power-down status flag.
    output reg        sys_osc_run_o,         // System oscillator runs.
    output reg        internal_rc_oscillator_run_o, // RC osc runs.
    output reg        clock_out_pin_o        // System clock divided by 4.
);
    // ****************************************************************
    // Timing constants
    // ****************************************************************
    localparam integer IRC_CYC = `WDOG_IRC_PERIOD_NS / `WDOG_SYS_PERIOD_NS;
    localparam integer W = `WDOG_CNT_W;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    reg       rst_s1_q, rst_s2_q;
    reg [7:0] pa_s1_q, pa_s2_q, pa_prev_q;

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_s1_q  <= 1'b1;
            rst_s2_q  <= 1'b1;
            pa_s1_q   <= 8'hff;
            pa_s2_q   <= 8'hff;
            pa_prev_q <= 8'hff;
        end else begin
            rst_s1_q  <= external_reset_pin_n_i;
            rst_s2_q  <= rst_s1_q;
            pa_s1_q   <= port_a_i;
            pa_s2_q   <= pa_s1_q;
            pa_prev_q <= pa_s2_q;
        end
    end

    wire pin_reset = ~rst_s2_q;

    // ****************************************************************
    // Clock sources
    // ****************************************************************
    // A real RC oscillator cannot exist in RTL, so the internal RC is
    // modelled as an enable pulse at its nominal 65 us period.
    wire irc_tick;
    wire instr_tick;
    // Oscillator gating: system clock stops in idle and halt.
    wire low_power = halted_o | idle_mode_i;
    wire irc_run = (irc_option_i | internal_osc_keep_enable_i |
                    wdt_enable_i) & // RULE17
                   (~low_power | internal_osc_keep_enable_i |
                    (halted_o & wdt_enable_i)); // RULE13 RULE14

    wdog_tick_div #(
        .DIV (IRC_CYC)
    ) u_irc_div (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .run_i     (irc_run), // RULE1 RULE5
        .tick_o    (irc_tick)
    );

    wdog_tick_div #(
        .DIV (`WDOG_INSTR_DIV)
    ) u_instr_div (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .run_i     (~low_power), // RULE6
        .tick_o    (instr_tick)
    );

    // ****************************************************************
    // Clear logic
    // ****************************************************************
    reg first_seen_q, second_seen_q;
    wire clr_single = wdt_enable_i & clear_watchdog_single_i &
                      (clr_mode_i == `WDOG_CLR_SINGLE); // RULE3 RULE11
    wire dual_first = wdt_enable_i & clear_watchdog_first_i &
                      (clr_mode_i == `WDOG_CLR_DUAL); // RULE3
    wire dual_second = wdt_enable_i & clear_watchdog_second_i &
                       (clr_mode_i == `WDOG_CLR_DUAL); // RULE3
    wire clr_dual = (dual_first | first_seen_q) &
                    (dual_second | second_seen_q); // RULE12
    wire halt_go = halt_exec_i & ~halted_o;
    wire sw_clear = clr_single | clr_dual;
    wire wdt_clear = pin_reset | sw_clear | halt_go; // RULE10

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            first_seen_q  <= 1'b0;
            second_seen_q <= 1'b0;
        end else if (clr_dual | pin_reset) begin
            first_seen_q  <= 1'b0;
            second_seen_q <= 1'b0;
        end else begin
            first_seen_q  <= first_seen_q | dual_first;
            second_seen_q <= second_seen_q | dual_second;
        end
    end

    // ****************************************************************
    // Watchdog counter
    // ****************************************************************
    reg  [W-1:0] watchdog_counter_q;
    wire         src_tick = (wdt_src_i == `WDOG_SRC_IRC) ? irc_tick
                                                        : instr_tick; // RULE2
    localparam [3:0] BASE_EXP = `WDOG_DIV_BASE_EXP;
    wire [3:0]   stage = BASE_EXP + {2'b00, wdt_div_sel_i};
    wire [W:0]   cnt_inc = {1'b0, watchdog_counter_q} + {{W{1'b0}}, 1'b1};
    // The mask covers the counter bits below the selected stage.
    wire [W-1:0] stage_mask = ({{(W-1){1'b0}}, 1'b1} << stage) -
                              {{(W-1){1'b0}}, 1'b1};
    // Overflow when the bits below the selected stage would roll over. RULE4
    wire         at_top = &(watchdog_counter_q | ~stage_mask);
    wire         overflow = wdt_enable_i & src_tick & at_top & ~wdt_clear;

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            watchdog_counter_q <= {W{1'b0}};
        end else if (wdt_clear | overflow | ~wdt_enable_i) begin
            watchdog_counter_q <= {W{1'b0}}; // RULE19
        end else if (src_tick) begin
            watchdog_counter_q <= cnt_inc[W-1:0]; // RULE19
        end
    end

    // ****************************************************************
    // Resets, wake-up and status flags
    // ****************************************************************
    wire pa_fall = |(pa_prev_q & ~pa_s2_q & port_a_wake_en_i);
    wire wake_ev = low_power & (irq_pending_i | pa_fall | overflow |
                   timer_flag_set_i | pin_reset); // RULE15

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            chip_reset_o     <= 1'b0;
            warm_reset_o     <= 1'b0;
            wake_o           <= 1'b0;
            halted_o         <= 1'b0;
            timeout_flag_o   <= 1'b0;
            powerdown_flag_o <= 1'b0;
        end else begin
            chip_reset_o <= pin_reset | (overflow & ~low_power); // RULE8
            warm_reset_o <= overflow & low_power; // RULE9
            wake_o       <= wake_ev;
            if (halt_go) begin
                halted_o <= 1'b1;
            end else if (wake_ev) begin
                halted_o <= 1'b0;
            end
            // A same-cycle clear suppresses overflow, so the flag is not set.
            if (overflow) begin
                timeout_flag_o <= 1'b1; // RULE8
            end else if (halt_go | sw_clear) begin
                timeout_flag_o <= 1'b0; // RULE18
            end
            if (halt_go) begin
                powerdown_flag_o <= 1'b1; // RULE18
            end else if (sw_clear) begin
                powerdown_flag_o <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Oscillator status and clock output
    // ****************************************************************
    reg [1:0] ck_div_q;

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ck_div_q                     <= 2'b00;
            clock_out_pin_o              <= 1'b0;
            sys_osc_run_o                <= 1'b1;
            internal_rc_oscillator_run_o <= 1'b0;
        end else begin
            if (!low_power) begin
                ck_div_q <= ck_div_q + 2'b01;
            end
            clock_out_pin_o              <= ck_div_q[1]; // RULE16
            sys_osc_run_o                <= ~low_power; // RULE13
            internal_rc_oscillator_run_o <= irc_run; // RULE14
        end
    end
endmodule // wdog_core
`default_nettype wire

//--- wdog_core_chk.sv
// Checker for the watchdog core: port-level timing relations.
// Assumes a bind onto wdog_core from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module wdog_core_chk (
    input wire       clock_i, sys_rst_i, wdt_enable_i, clr_mode_i,
    input wire       irc_option_i, internal_osc_keep_enable_i,
    input wire       idle_mode_i, halt_exec_i, clear_watchdog_single_i,
    input wire       external_reset_pin_n_i, irq_pending_i,
    input wire       chip_reset_o, warm_reset_o, wake_o, halted_o,
    input wire       timeout_flag_o, powerdown_flag_o, sys_osc_run_o,
    input wire       internal_rc_oscillator_run_o, clock_out_pin_o
);
    // Settle counter keeps $past away from reset and from low-power
    // spans, in which the clock output divider is frozen.
    logic [2:0] up_q;
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) up_q <= 3'h0;
        else if (halted_o || idle_mode_i) up_q <= 3'h0;
        else if (up_q != 3'h7) up_q <= up_q + 3'h1;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    clk_out_a: assert property (up_q == 3'h7 |->
        clock_out_pin_o != $past(clock_out_pin_o, 2) &&
        clock_out_pin_o == $past(clock_out_pin_o, 4)) else $error("clkout");
    halt_flag_a: assert property (halt_exec_i && wdt_enable_i &&
        !halted_o && external_reset_pin_n_i |=> powerdown_flag_o)
        else $error("halt flag");
    single_clr_a: assert property (clear_watchdog_single_i &&
        wdt_enable_i && !clr_mode_i && !halt_exec_i |=> !powerdown_flag_o)
        else $error("single clear");
    disabled_a: assert property (!wdt_enable_i && !halt_exec_i
        |=> !$rose(timeout_flag_o)) else $error("disabled timeout");
    to_rst_a: assert property ($rose(timeout_flag_o) |->
        chip_reset_o || warm_reset_o) else $error("flag without reset");
    warm_rst_a: assert property (warm_reset_o |->
        wake_o && timeout_flag_o && !chip_reset_o) else $error("warm");
    pin_rst_a: assert property ($fell(external_reset_pin_n_i)
        |-> ##[1:4] chip_reset_o) else $error("pin reset");
    idle_osc_a: assert property (idle_mode_i [*2]
        |-> !sys_osc_run_o) else $error("idle osc");
    rc_keep_a: assert property ((idle_mode_i &&
        internal_osc_keep_enable_i) [*2] |-> internal_rc_oscillator_run_o)
        else $error("rc keep");
    rc_off_a: assert property ((!irc_option_i &&
        !internal_osc_keep_enable_i && !wdt_enable_i) [*2]
        |-> !internal_rc_oscillator_run_o) else $error("rc off");
    wake_irq_a: assert property (halted_o && irq_pending_i
        |-> ##[1:3] wake_o) else $error("wake");
endmodule // wdog_core_chk
`default_nettype wire

//--- wdog_map.vh
// Constants for the watchdog and oscillator gating block.
// Assumes inclusion by bare name from the design files in this folder.
`ifndef WDOG_MAP_VH
`define WDOG_MAP_VH
// Internal RC period in ns and system clock period in ns.
`define WDOG_IRC_PERIOD_NS   65000
`define WDOG_SYS_PERIOD_NS   5
// Instruction clock divide ratio.
`define WDOG_INSTR_DIV       4
// Divide ratio selection: 2^(12+sel).
`define WDOG_DIV_BASE_EXP    12
`define WDOG_CNT_W           16
// Clock source codes.
`define WDOG_SRC_IRC         1'b0
`define WDOG_SRC_INSTR       1'b1
// Clear policy codes.
`define WDOG_CLR_SINGLE      1'b0
`define WDOG_CLR_DUAL        1'b1
`endif

//--- wdog_tick_div.v
// Tick divider producing one-cycle enable pulses every DIV clocks.
// Assumes a single clock domain; run_i gates counting.
`timescale 1ns/1ps
`default_nettype none
module wdog_tick_div #(
    parameter integer DIV = 4
) (
    input  wire clock_i,   // System clock.
    input  wire sys_rst_i, // Async reset, active high.
    input  wire run_i,     // Count enable.
    output reg  tick_o     // One-cycle pulse.
);
    reg [15:0] cnt_q;

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q  <= 16'h0000;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            tick_o <= 1'b0;
        end else if (cnt_q == DIV[15:0] - 16'h0001) begin
            cnt_q  <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule // wdog_tick_div
`default_nettype wire
